/* File: hdl/load_decode_pkg.sv */
// Constants for the compact byte and halfword load decoder
package load_decode_pkg;
  // Major opcodes in bits 15:11
  localparam logic [4:0] OP_LOAD_SIGNED_BYTE = 5'h10;
  localparam logic [4:0] OP_LOAD_UNSIGNED_BYTE = 5'h14;
  localparam logic [4:0] OP_LOAD_SIGNED_HALFWORD = 5'h11;
  localparam logic [4:0] OP_EXTEND_PREFIX = 5'h1E;
  // Field positions
  localparam int OPCODE_MSB = 15;
  localparam int OPCODE_LSB = 11;
  localparam int BASE_MSB = 10;
  localparam int BASE_LSB = 8;
  localparam int DEST_MSB = 7;
  localparam int DEST_LSB = 5;
  localparam int OFFS_MSB = 4;
  localparam int OFFS_LSB = 0;
  localparam int PFX_MID_MSB = 10;
  localparam int PFX_MID_LSB = 5;
  localparam int PFX_HI_MSB = 4;
  localparam int PFX_HI_LSB = 0;
  // Reset values
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [4:0] REG_RESET = 5'h00;
  // Load sizes for the memory path
  localparam logic SIZE_BYTE = 1'b0;
  localparam logic SIZE_HALF = 1'b1;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM = 3'b010,
    ST_DONE = 3'b100
  } state_type;
endpackage

/* File: hdl/compact_load_decode.sv */
// Decoder and executor for compact byte and halfword loads
`timescale 1ns/10ps

// Contract
// - Opcode 10000 is signed byte load; base 10:8, dest 7:5, offset 4:0.
// - Opcode 10100 is unsigned byte load with the same fields.
// - Opcode 10001 is signed halfword load with the same fields.
// - Prefix 11110 forms 16-bit offset, sign-extended before adding to base.
// - Short byte loads zero-extend the unscaled 5-bit offset.
// - Short halfword load shifts offset left one, zero-extends it.
// - Signed byte load sign-extends the fetched byte.
// - Unsigned byte load zero-extends the fetched byte.
// - Halfword load sign-extends the fetched halfword in both forms.
// - Odd halfword address raises address error with no memory access.
// - Byte loads flip both low address bits; lane uses big-endian flag twice.
// - Halfword loads flip address bit 1 only; lane flips bit 1 only.
// - Halfword loads may raise only refill, invalid, bus and address errors.
module compact_load_decode #(
  parameter int ADDR_WIDTH = 32
) (
  input wire logic ref_clk, // Core clock
  input wire logic reset, // Async reset, active high
  input wire logic issueValid, // Instruction presented, one cycle
  input wire logic [31:0] instrWord, // Prefix in 31:16 when extended
  input wire logic extended, // Instruction carries a prefix
  input wire logic reverse_endian_flag, // Reverse-endian mode
  input wire logic big_endian_flag, // Big-endian core
  output logic [4:0] baseRegNum, // Architectural base register
  input wire logic [31:0] baseValue, // Base register contents, same cycle
  output logic memReq, // Translated load request pulse
  output logic [ADDR_WIDTH-1:0] memVAddr, // Virtual address to translate
  output logic memSize, // Byte or halfword
  input wire logic memDone, // Load answer pulse
  input wire logic [ADDR_WIDTH-1:0] memPAddr, // Translated physical address
  input wire logic [31:0] memWord, // Fetched word
  input wire logic tlbRefill, // Translation refill fault
  input wire logic tlbInvalid, // Translation invalid fault
  input wire logic busError, // Bus error on fetch
  output logic [ADDR_WIDTH-1:0] physAddr, // Endian-adjusted physical address
  output logic wrEn, // Destination write pulse
  output logic [4:0] wrRegNum, // Architectural destination register
  output logic [31:0] wrData, // Extended load result
  output logic excValid, // Exception pulse
  output logic [3:0] excCause, // One bit each: addr, refill, invalid, bus
  output logic busy // Load in flight
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Fixed compact register translation: 0,1 -> 16,17; 2..7 -> 2..7
  function automatic logic [4:0] xlatReg(input logic [2:0] f);
    xlatReg = (f < 3'h2) ? {2'b10, f} : {2'b00, f};
  endfunction

  logic [4:0] opcode;
  logic isSb, isUb, isSh, isLoad, prefixOk;
  logic [15:0] extOffset;
  logic [ADDR_WIDTH-1:0] offsetAdd, effAddr;

  // Decode of the incoming instruction
  always_comb begin
    opcode = instrWord[load_decode_pkg::OPCODE_MSB:load_decode_pkg::OPCODE_LSB];
    isSb = (opcode == load_decode_pkg::OP_LOAD_SIGNED_BYTE);
    isUb = (opcode == load_decode_pkg::OP_LOAD_UNSIGNED_BYTE);
    isSh = (opcode == load_decode_pkg::OP_LOAD_SIGNED_HALFWORD);
    prefixOk = !extended || (instrWord[31:27] == load_decode_pkg::OP_EXTEND_PREFIX);
    isLoad = issueValid && prefixOk && (isSb || isUb || isSh);
    baseRegNum = xlatReg(instrWord[load_decode_pkg::BASE_MSB:load_decode_pkg::BASE_LSB]);
    // Prefix 26:21 gives offset 10:5, prefix 20:16 gives 15:11
    extOffset = {instrWord[20:16], instrWord[26:21],
                 instrWord[load_decode_pkg::OFFS_MSB:load_decode_pkg::OFFS_LSB]};
    if (extended) begin
      offsetAdd = ADDR_WIDTH'({{(ADDR_WIDTH-16){extOffset[15]}}, extOffset});
    end else if (isSh) begin
      offsetAdd = ADDR_WIDTH'({instrWord[4:0], 1'b0});
    end else begin
      offsetAdd = ADDR_WIDTH'(instrWord[4:0]);
    end
    effAddr = ADDR_WIDTH'(baseValue) + offsetAdd;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  load_decode_pkg::state_type state_r, state_nxt;
  logic signed_r, signed_nxt, half_r, half_nxt;
  logic [4:0] dest_r, dest_nxt;
  logic memReq_r, memReq_nxt, memSize_r, memSize_nxt;
  logic [ADDR_WIDTH-1:0] vAddr_r, vAddr_nxt, physAddr_r, physAddr_nxt;
  logic wrEn_r, wrEn_nxt, excValid_r, excValid_nxt;
  logic [4:0] wrReg_r, wrReg_nxt;
  logic [31:0] wrData_r, wrData_nxt;
  logic [3:0] excCause_r, excCause_nxt;
  logic busy_r, busy_nxt;
  logic [1:0] lane;
  logic [7:0] selByte;
  logic [15:0] selHalf;

  // Next state, lane selection and extension
  always_comb begin
    state_nxt = state_r;
    signed_nxt = signed_r;
    half_nxt = half_r;
    dest_nxt = dest_r;
    memReq_nxt = 1'b0;
    memSize_nxt = memSize_r;
    vAddr_nxt = vAddr_r;
    physAddr_nxt = physAddr_r;
    wrEn_nxt = 1'b0;
    excValid_nxt = 1'b0;
    wrReg_nxt = wrReg_r;
    wrData_nxt = wrData_r;
    excCause_nxt = excCause_r;
    // Big-endian flips both lane bits for bytes, only bit 1 for halves
    lane = vAddr_r[1:0] ^ (half_r ? {big_endian_flag, 1'b0}
                                  : {2{big_endian_flag}});
    selByte = memWord[8*lane +: 8];
    selHalf = memWord[8*lane +: 16];
    unique case (state_r)
      load_decode_pkg::ST_IDLE: begin
        if (isLoad) begin
          signed_nxt = !isUb;
          half_nxt = isSh;
          dest_nxt = xlatReg(instrWord[load_decode_pkg::DEST_MSB:load_decode_pkg::DEST_LSB]);
          vAddr_nxt = effAddr;
          // Misaligned halfword stops before translation or access
          if (isSh && effAddr[0]) begin
            excValid_nxt = 1'b1;
            excCause_nxt = 4'h1;
            state_nxt = load_decode_pkg::ST_DONE;
          end else begin
            memReq_nxt = 1'b1;
            memSize_nxt = isSh ? load_decode_pkg::SIZE_HALF : load_decode_pkg::SIZE_BYTE;
            state_nxt = load_decode_pkg::ST_MEM;
          end
        end
      end
      load_decode_pkg::ST_MEM: begin
        if (memDone) begin
          state_nxt = load_decode_pkg::ST_DONE;
          physAddr_nxt = {memPAddr[ADDR_WIDTH-1:2], memPAddr[1:0] ^ (half_r
            ? {reverse_endian_flag, 1'b0} : {2{reverse_endian_flag}})};
          if (tlbRefill || tlbInvalid || busError) begin
            // Only the translation and bus faults may arise here
            excValid_nxt = 1'b1;
            excCause_nxt = {busError, tlbInvalid, tlbRefill, 1'b0};
          end else begin
            wrEn_nxt = 1'b1;
            wrReg_nxt = dest_r;
            if (half_r) begin
              wrData_nxt = {{16{selHalf[15]}}, selHalf};
            end else if (signed_r) begin
              wrData_nxt = {{24{selByte[7]}}, selByte};
            end else begin
              wrData_nxt = {24'h00_0000, selByte};
            end
          end
        end
      end
      load_decode_pkg::ST_DONE: begin
        state_nxt = load_decode_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = load_decode_pkg::ST_IDLE;
      end
    endcase
    // Registered so the busy pin comes straight from a flop
    busy_nxt = (state_nxt != load_decode_pkg::ST_IDLE);
  end

  // Registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= load_decode_pkg::ST_IDLE;
      signed_r <= 1'b0;
      half_r <= 1'b0;
      dest_r <= load_decode_pkg::REG_RESET;
      memReq_r <= 1'b0;
      memSize_r <= load_decode_pkg::SIZE_BYTE;
      vAddr_r <= '0;
      physAddr_r <= '0;
      wrEn_r <= 1'b0;
      excValid_r <= 1'b0;
      wrReg_r <= load_decode_pkg::REG_RESET;
      wrData_r <= load_decode_pkg::DATA_RESET;
      excCause_r <= 4'h0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      signed_r <= signed_nxt;
      half_r <= half_nxt;
      dest_r <= dest_nxt;
      memReq_r <= memReq_nxt;
      memSize_r <= memSize_nxt;
      vAddr_r <= vAddr_nxt;
      physAddr_r <= physAddr_nxt;
      wrEn_r <= wrEn_nxt;
      excValid_r <= excValid_nxt;
      wrReg_r <= wrReg_nxt;
      wrData_r <= wrData_nxt;
      excCause_r <= excCause_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Outputs straight from flops
  assign memReq = memReq_r;
  assign memVAddr = vAddr_r;
  assign memSize = memSize_r;
  assign physAddr = physAddr_r;
  assign wrEn = wrEn_r;
  assign wrRegNum = wrReg_r;
  assign wrData = wrData_r;
  assign excValid = excValid_r;
  assign excCause = excCause_r;
  assign busy = busy_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence oddHalfIssue;
    issueValid && isSh && prefixOk && effAddr[0] && state_r == load_decode_pkg::ST_IDLE;
  endsequence

  a_odd_half_fault: assert property (oddHalfIssue |=> excValid && excCause == 4'h1 && !memReq)
    else $error("misaligned halfword did not fault");
  a_odd_no_access: assert property (oddHalfIssue |=> ##1 !memReq)
    else $error("misaligned halfword reached memory");
  a_byte_req_issued: assert property (isLoad && !isSh && state_r == load_decode_pkg::ST_IDLE
    |=> memReq && memSize == load_decode_pkg::SIZE_BYTE)
    else $error("byte load not issued");
  a_short_byte_addr: assert property (isLoad && !extended && !isSh && state_r[0]
    |=> memVAddr == $past(baseValue) + {27'h0, $past(instrWord[4:0])})
    else $error("short byte address wrong");
  a_short_half_addr: assert property (isLoad && !extended && isSh && state_r[0]
    |=> memVAddr == $past(baseValue) + {26'h0, $past(instrWord[4:0]), 1'b0})
    else $error("short halfword address wrong");
  a_ext_offset_sign: assert property (isLoad && extended && state_r[0]
    |=> memVAddr == $past(baseValue) + {{16{$past(instrWord[20])}}, $past(instrWord[20:16]),
      $past(instrWord[26:21]), $past(instrWord[4:0])})
    else $error("extended offset wrong");
  a_half_sign_ext: assert property (wrEn && half_r |-> wrData[31:16] == {16{wrData[15]}})
    else $error("halfword not sign-extended");
  a_ubyte_zero_ext: assert property (wrEn && !signed_r |-> wrData[31:8] == 24'h00_0000)
    else $error("unsigned byte not zero-extended");
  a_sbyte_sign_ext: assert property (wrEn && signed_r && !half_r
    |-> wrData[31:8] == {24{wrData[7]}})
    else $error("signed byte not sign-extended");
  a_fault_no_write: assert property (memDone && state_r == load_decode_pkg::ST_MEM
    && (tlbRefill || busError) |=> excValid && !wrEn)
    else $error("fault still wrote register");
  a_reg_xlat: assert property (wrEn |-> wrRegNum inside {5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h07, 5'h10, 5'h11})
    else $error("destination outside compact set");
endmodule

/* File: verif/load_path_model.sv */
// Behavioural load path with address translation for the load decoder bench
`timescale 1ns/10ps
module load_path_model #(
  parameter logic [31:0] PAGE_FLIP = 32'h4000_0000
) (
  input wire logic ref_clk, // Core clock
  input wire logic memReq, // Request pulse
  input wire logic [31:0] memVAddr, // Virtual address
  input wire logic [3:0] delay, // Extra answer cycles
  input wire logic [2:0] fault, // Bus, invalid, refill
  input wire logic [31:0] word, // Word to return
  output logic memDone, // Answer pulse
  output logic [31:0] memPAddr, // Translated address
  output logic [31:0] memWord, // Fetched word
  output logic tlbRefill, // Refill fault
  output logic tlbInvalid, // Invalid fault
  output logic busError // Bus error
);
  // Answer after the commanded wait; address and word lines invert outside the answer
  // so a late sample never sees a stale value by luck
  initial begin
    {memDone, tlbRefill, tlbInvalid, busError} = 4'h0;
    memPAddr = 32'h0;
    memWord = 32'h0;
    forever begin
      @(posedge ref_clk);
      if (memReq === 1'b1) begin
        repeat (delay) @(posedge ref_clk);
        memDone <= 1'b1;
        memPAddr <= memVAddr ^ PAGE_FLIP;
        memWord <= word;
        {busError, tlbInvalid, tlbRefill} <= fault;
        @(posedge ref_clk);
        memDone <= 1'b0;
        memPAddr <= ~memPAddr;
        memWord <= ~memWord;
        {busError, tlbInvalid, tlbRefill} <= 3'h0;
      end
    end
  end
endmodule

/* File: verif/compact_load_decode_test.sv */
// Self-checking bench for the compact byte and halfword load decoder
`timescale 1ns/10ps
module compact_load_decode_test;
  localparam logic [31:0] PAGE_FLIP = 32'h4000_0000;
  localparam logic [4:0] OP_SB = load_decode_pkg::OP_LOAD_SIGNED_BYTE;
  localparam logic [4:0] OP_UB = load_decode_pkg::OP_LOAD_UNSIGNED_BYTE;
  localparam logic [4:0] OP_H = load_decode_pkg::OP_LOAD_SIGNED_HALFWORD;
  logic ref_clk, reset, issueValid, extended, revFlag, bigFlag, memReq, memSize, memDone;
  logic tlbRefill, tlbInvalid, busError, wrEn, excValid, busy;
  logic [31:0] instrWord, baseValue, memVAddr, memPAddr, memWord, physAddr, wrData, word;
  logic [4:0] baseRegNum, wrRegNum;
  logic [3:0] excCause, delay;
  logic [2:0] fault;
  int errors = 0, checks = 0, reqs = 0;

  compact_load_decode DUT (.ref_clk, .reset, .issueValid, .instrWord, .extended,
    .reverse_endian_flag(revFlag), .big_endian_flag(bigFlag), .baseRegNum, .baseValue,
    .memReq, .memVAddr, .memSize, .memDone, .memPAddr, .memWord, .tlbRefill, .tlbInvalid,
    .busError, .physAddr, .wrEn, .wrRegNum, .wrData, .excValid, .excCause, .busy);
  load_path_model #(.PAGE_FLIP(PAGE_FLIP)) PATH (.ref_clk, .memReq, .memVAddr, .delay,
    .fault, .word, .memDone, .memPAddr, .memWord, .tlbRefill, .tlbInvalid, .busError);

  // Core clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Load requests counted once outputs have settled
  always @(negedge ref_clk) if (memReq === 1'b1) reqs++;

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (exp !== got) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("%0d checks, %0d errors", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [4:0] xl(logic [2:0] r);
    return (r < 3'h2) ? {2'b10, r} : {2'b00, r};
  endfunction

  // One load issued, answered and judged against the load arithmetic
  task automatic ld(logic [4:0] op, logic ext, logic [15:0] off, logic [2:0] ry,
                    logic [31:0] base, logic [1:0] flags);
    logic half, mis;
    logic [31:0] va, pa, data;
    int lane, n;
    half = (op == OP_H);
    va = base + (ext ? {{16{off[15]}}, off}
                     : half ? {26'h0, off[4:0], 1'b0} : {27'h0, off[4:0]});
    mis = half && va[0];
    reqs = 0;
    @(posedge ref_clk);
    issueValid <= 1'b1;
    extended <= ext;
    instrWord <= {ext ? {5'h1E, off[10:5], off[15:11]} : 16'h0000, op, ~ry, ry, off[4:0]};
    baseValue <= base;
    {revFlag, bigFlag} <= flags;
    @(negedge ref_clk);
    check("baseRegNum", {27'h0, xl(~ry)}, {27'h0, baseRegNum});
    @(posedge ref_clk);
    issueValid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (wrEn !== 1'b1 && excValid !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      results();
    end
    check("busy at result", 32'h1, {31'h0, busy});
    if (mis || fault != 3'h0) begin
      check("excCause", {28'h0, mis ? 4'h1 : {fault, 1'b0}}, {28'h0, excCause});
      check("wrEn", 32'h0, {31'h0, wrEn});
      check("memReq count", mis ? 32'h0 : 32'h1, reqs);
    end else begin
      lane = int'(va[1:0] ^ {bigFlag, bigFlag & ~half});
      pa = va ^ PAGE_FLIP;
      pa[1:0] = pa[1:0] ^ {revFlag, revFlag & ~half};
      data = half ? {{16{word[8*lane+15]}}, word[8*lane+:16]}
                  : {{24{word[8*lane+7] & (op == OP_SB)}}, word[8*lane+:8]};
      check("memVAddr", va, memVAddr);
      check("memSize", {31'h0, half}, {31'h0, memSize});
      check("physAddr", pa, physAddr);
      check("wrData", data, wrData);
      check("wrRegNum", {27'h0, xl(ry)}, {27'h0, wrRegNum});
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("busy after result", 32'h0, {31'h0, busy});
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  // Short forms over all lanes, endian pairs, offsets and answer delays
  task automatic test_short();
    for (int i = 0; i < 24; i++) begin
      delay <= 4'(i % 5);
      ld(i < 8 ? OP_SB : i < 16 ? OP_UB : OP_H, 1'b0, 16'(i * 9), i[2:0],
         32'h0000_1000 + 32'(2 * i), i[1:0]);
    end
    $display("short forms done");
  endtask

  // Prefixed forms at both ends of the signed range, one halfword of them odd
  task automatic test_ext();
    logic [15:0] offs [6] = '{16'hFFFF, 16'h8000, 16'h7FFE, 16'hFFFE, 16'h07E1, 16'h0421};
    for (int i = 0; i < 6; i++) begin
      ld(i % 3 == 0 ? OP_SB : i % 3 == 1 ? OP_UB : OP_H, 1'b1, offs[i], 3'h5,
         32'h0001_0000, i[1:0]);
    end
    $display("extended forms done");
  endtask

  // Short misaligned halfword, then each translation or bus fault
  task automatic test_err();
    ld(OP_H, 1'b0, 16'h001F, 3'h0, 32'h0000_3001, 2'h3);
    for (int i = 0; i < 3; i++) begin
      fault <= 3'(1 << i);
      ld(OP_H, 1'b0, 16'h0002, 3'h1, 32'h0000_4000, 2'h0);
    end
    fault <= 3'h0;
    $display("error cases done");
  endtask

  // Unknown opcode and a load behind a wrong prefix are both ignored
  task automatic test_refuse();
    reqs = 0;
    @(posedge ref_clk);
    issueValid <= 1'b1;
    extended <= 1'b0;
    instrWord <= {16'h0000, 5'h15, 3'h2, 3'h3, 5'h04};
    baseValue <= 32'h0000_2000;
    @(posedge ref_clk);
    extended <= 1'b1;
    instrWord <= {5'h1D, 11'h000, OP_SB, 3'h2, 3'h3, 5'h04};
    @(posedge ref_clk);
    issueValid <= 1'b0;
    extended <= 1'b0;
    repeat (6) @(negedge ref_clk);
    check("refused memReq count", 32'h0, reqs);
    check("refused busy", 32'h0, {31'h0, busy});
    $display("refused forms done");
  endtask

  // Reset in mid-load: outputs return to rest and the late answer is ignored
  task automatic test_reset();
    int seen;
    seen = 0;
    delay <= 4'h6;
    @(posedge ref_clk);
    issueValid <= 1'b1;
    extended <= 1'b0;
    instrWord <= {16'h0000, OP_SB, 3'h2, 3'h3, 5'h04};
    baseValue <= 32'h0000_2000;
    @(posedge ref_clk);
    issueValid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b1;
    @(negedge ref_clk);
    check("busy in reset", 32'h0, {31'h0, busy});
    check("memVAddr in reset", 32'h0, memVAddr);
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    // The model still answers the cut load; an idle decoder must ignore it
    repeat (12) begin
      @(negedge ref_clk);
      if (wrEn !== 1'b0 || excValid !== 1'b0 || busy !== 1'b0) seen++;
    end
    check("activity after reset", 32'h0, seen);
    delay <= 4'h0;
    ld(OP_UB, 1'b0, 16'h0007, 3'h4, 32'h0000_2001, 2'h1);
    $display("mid-run reset done");
  endtask

  // Reset for ten cycles, then the scenarios in turn
  initial begin
    {reset, issueValid, extended, revFlag, bigFlag} = 5'h10;
    {instrWord, baseValue} = 64'h0;
    {delay, fault} = 7'h0;
    word = 32'h80FF_7F01;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    test_short();
    test_ext();
    test_err();
    test_refuse();
    test_reset();
    results();
  end
endmodule
